// *** rtl/cell_port_consts.svh ***
// Constants for the PHY-side cell port
`ifndef CELL_PORT_CONSTS_SVH
`define CELL_PORT_CONSTS_SVH
`define CELL_BYTES        53
`define RX_LINK_MAX_MHZ   40
`define TX_LINK_MIN_MHZ   20
`define TX_LINK_MAX_MHZ   40
`define FIFO_DEPTH_LOG2   7
`define DEFAULT_PHY_ADDR  5'h00
`endif

// *** rtl/cell_port_pkg.sv ***
// Types for the PHY-side cell port
package cell_port_pkg;
    typedef enum logic [0:0] {
        HS_BYTE = 1'b0,
        HS_CELL = 1'b1
    } handshake_t;
    typedef logic [7:0] byte_t;
endpackage

// *** rtl/utopia_phy_cell_port.sv ***
// PHY-side byte/cell port towards an ATM layer master
//
// Overview of operation
// - Receive bytes are driven out, changing on receive link clock rising edges.
// - Receive start-of-cell is high while a cell's first byte is out.
// - Byte handshake: receive-empty low whenever the receive buffer holds nothing.
// - Cell handshake: cell-available high only with a whole cell buffered.
// - Receive outputs drive two-state or tri-statable according to the mode.
// - Multi-PHY: receive address decides whether this PHY is selected.
// - Transmit bytes sampled on transmit link clock rising edges.
// - Byte handshake: transmit-full low whenever the transmit buffer has no room.
// - Cell handshake: cell room high only with space for a whole cell.
// - Multi-PHY: transmit address decides whether this PHY is selected.
// - multi_phy_select high gives multi-PHY mode, low single-PHY.
`timescale 1ns/10ps
`include "cell_port_consts.svh"

module utopia_phy_cell_port #(
    parameter int       AW       = `FIFO_DEPTH_LOG2,
    parameter int       CELL_LEN = `CELL_BYTES,
    parameter bit [4:0] PHY_ADDR = `DEFAULT_PHY_ADDR
) (
    input  wire logic       REF_CLK,
    input  wire logic       RST_N,
    input  wire logic       CELL_MODE,
    input  wire logic       MULTI_PHY_SELECT,
    input  wire logic       RX_LINK_CLOCK,
    output logic [7:0]      RX_BYTE_BUS,
    output logic [7:0]      RX_BYTE_BUS_OE_N,
    output logic            RX_CELL_START,
    output logic            RX_CELL_START_OE_N,
    output logic            RX_STATUS,
    output logic            RX_STATUS_OE_N,
    input  wire logic       RX_ACCEPT_N,
    input  wire logic [4:0] RX_PHY_SELECT_ADDR,
    input  wire logic [7:0] CORE_RX_BYTE,
    input  wire logic       CORE_RX_SOC,
    input  wire logic       CORE_RX_VALID,
    output logic            CORE_RX_READY,
    input  wire logic       TX_LINK_CLOCK,
    input  wire logic [7:0] TX_BYTE_BUS,
    input  wire logic       TX_CELL_START,
    input  wire logic       TX_VALID_N,
    input  wire logic [4:0] TX_PHY_SELECT_ADDR,
    output logic            TX_STATUS,
    output logic            TX_STATUS_OE_N,
    output logic [7:0]      CORE_TX_BYTE,
    output logic            CORE_TX_SOC,
    output logic            CORE_TX_VALID,
    input  wire logic       CORE_TX_READY
);
    localparam int DEPTH = 1 << AW;

    // Two-flop synchronisers for every pin coming from the link
    logic [1:0] rclk_s_q;
    logic [1:0] tx_link_clock_s_q;
    logic [1:0] racc_s_q;
    logic [1:0] tval_s_q;
    logic [1:0] tx_cell_start_s_q;
    logic [1:0] mode_s_q;
    logic [1:0] mphy_s_q;
    logic [4:0] radd_s1_q;
    logic [4:0] radd_s2_q;
    logic [4:0] tadd_s1_q;
    logic [4:0] tadd_s2_q;
    logic [7:0] tdat_s1_q;
    logic [7:0] tdat_s2_q;
    // Previous sampled link clock levels for edge detection
    logic       rclk_d1_q;
    logic       tx_link_clock_d1_q;

    // Enables reset to idle high so no false transfer follows reset
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rclk_s_q <= 2'h0;
            tx_link_clock_s_q <= 2'h0;
            racc_s_q <= 2'h3;
            tval_s_q <= 2'h3;
            tx_cell_start_s_q <= 2'h0;
            mode_s_q <= 2'h0;
            mphy_s_q <= 2'h0;
        end else begin
            rclk_s_q <= {rclk_s_q[0], RX_LINK_CLOCK};
            tx_link_clock_s_q <= {tx_link_clock_s_q[0], TX_LINK_CLOCK};
            racc_s_q <= {racc_s_q[0], RX_ACCEPT_N};
            tval_s_q <= {tval_s_q[0], TX_VALID_N};
            tx_cell_start_s_q <= {tx_cell_start_s_q[0], TX_CELL_START};
            mode_s_q <= {mode_s_q[0], CELL_MODE};
            mphy_s_q <= {mphy_s_q[0], MULTI_PHY_SELECT};
        end
    end

    // Buses are stable around the link edge, so per-bit sync stays coherent
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            radd_s1_q <= 5'h00;
            radd_s2_q <= 5'h00;
            tadd_s1_q <= 5'h00;
            tadd_s2_q <= 5'h00;
            tdat_s1_q <= 8'h00;
            tdat_s2_q <= 8'h00;
        end else begin
            radd_s1_q <= RX_PHY_SELECT_ADDR;
            radd_s2_q <= radd_s1_q;
            tadd_s1_q <= TX_PHY_SELECT_ADDR;
            tadd_s2_q <= tadd_s1_q;
            tdat_s1_q <= TX_BYTE_BUS;
            tdat_s2_q <= tdat_s1_q;
        end
    end

    // Link clocks are only sampled, never used as clocks
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rclk_d1_q <= 1'b0;
            tx_link_clock_d1_q <= 1'b0;
        end else begin
            rclk_d1_q <= rclk_s_q[1];
            tx_link_clock_d1_q <= tx_link_clock_s_q[1];
        end
    end

    wire        rclk_rise = rclk_s_q[1] & ~rclk_d1_q;
    wire        tx_link_clock_rise = tx_link_clock_s_q[1] & ~tx_link_clock_d1_q;
    wire        cell_hs   = (mode_s_q[1] == cell_port_pkg::HS_CELL);
    wire        multi_phy = mphy_s_q[1];
    wire        rx_sel    = !multi_phy || (radd_s2_q == PHY_ADDR);
    wire        tx_sel    = !multi_phy || (tadd_s2_q == PHY_ADDR);

    // Receive buffer: core fills, link drains
    cell_port_pkg::byte_t rx_mem [DEPTH];
    logic                 rx_soc_mem [DEPTH];
    logic [AW:0]          rx_wp_q, rx_rp_q;
    logic [AW:0]          rx_cells_q;
    wire  [AW:0]          rx_cnt   = rx_wp_q - rx_rp_q;
    wire                  rx_full  = rx_cnt[AW];
    wire                  rx_empty = (rx_cnt == '0);
    wire                  rx_push  = CORE_RX_VALID && !rx_full;
    // Whole-cell count rises on a cell's last byte written
    logic [5:0]           rx_wcnt_q;
    wire                  rx_wlast = rx_push && (rx_wcnt_q == 6'(CELL_LEN - 1));
    logic [5:0]           rx_rcnt_q;
    wire                  rx_has_cell  = (rx_cells_q != '0);
    wire                  rx_mid_cell  = (rx_rcnt_q != 6'h00);
    // Cell mode never starts a cell that is not wholly buffered
    wire                  rx_pop   = rclk_rise && !racc_s_q[1] && rx_sel && !rx_empty
                                     && (!cell_hs || rx_has_cell || rx_mid_cell);
    wire                  rx_first_pop = rx_pop && !rx_mid_cell;
    wire                  rx_near_full = (rx_cnt == DEPTH[AW:0] - 1'b1) && rx_push;
    wire                  rx_rlast = rx_pop && (rx_rcnt_q == 6'(CELL_LEN - 1));

    always_ff @(posedge REF_CLK) begin
        if (rx_push) begin
            rx_mem[rx_wp_q[AW-1:0]]     <= CORE_RX_BYTE;
            rx_soc_mem[rx_wp_q[AW-1:0]] <= CORE_RX_SOC;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rx_wp_q    <= '0;
            rx_rp_q    <= '0;
            rx_wcnt_q  <= 6'h00;
            rx_rcnt_q  <= 6'h00;
            rx_cells_q <= '0;
        end else begin
            if (rx_push) begin
                rx_wp_q   <= rx_wp_q + 1'b1;
                rx_wcnt_q <= rx_wlast ? 6'h00 : rx_wcnt_q + 6'h01;
            end
            if (rx_pop) begin
                rx_rp_q   <= rx_rp_q + 1'b1;
                rx_rcnt_q <= rx_rlast ? 6'h00 : rx_rcnt_q + 6'h01;
            end
            // Cell uncounted once its first byte leaves, so in-flight cells finish
            rx_cells_q <= rx_cells_q + {{AW{1'b0}}, rx_wlast}
                          - {{AW{1'b0}}, rx_first_pop};
        end
    end

    // Receive byte, start and status pins update only on a link rising edge
    wire rx_status_d = cell_hs ? rx_has_cell
                               : !rx_empty;    // low means empty
    wire rx_hiz      = multi_phy && !rx_sel;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            RX_BYTE_BUS   <= 8'h00;
            RX_CELL_START <= 1'b0;
            RX_STATUS     <= 1'b0;
        end else if (rclk_rise) begin
            if (rx_pop) begin
                RX_BYTE_BUS   <= rx_mem[rx_rp_q[AW-1:0]];
                RX_CELL_START <= rx_soc_mem[rx_rp_q[AW-1:0]];
            end else begin
                RX_CELL_START <= 1'b0;
            end
            RX_STATUS <= rx_status_d;
        end
    end

    // Ready drops one write early since it is registered
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            CORE_RX_READY <= 1'b0;
        end else begin
            CORE_RX_READY <= !rx_full && !rx_near_full;
        end
    end

    // Two-state in single-PHY mode; release follows the address every
    // cycle, not the link edge, so a deselected PHY frees the lines promptly
    generate
        for (genvar i = 0; i < 8; i++) begin : g_rx_oe
            always_ff @(posedge REF_CLK) begin
                if (!RST_N) begin
                    RX_BYTE_BUS_OE_N[i] <= 1'b1;
                end else begin
                    RX_BYTE_BUS_OE_N[i] <= rx_hiz;
                end
            end
        end
    endgenerate

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            RX_CELL_START_OE_N <= 1'b1;
            RX_STATUS_OE_N     <= 1'b1;
        end else begin
            RX_CELL_START_OE_N <= rx_hiz;
            RX_STATUS_OE_N     <= rx_hiz;
        end
    end

    // Transmit buffer: link fills, core drains
    cell_port_pkg::byte_t tx_mem [DEPTH];
    logic                 tx_soc_mem [DEPTH];
    logic [AW:0]          tx_wp_q, tx_rp_q;
    wire  [AW:0]          tx_cnt   = tx_wp_q - tx_rp_q;
    wire                  tx_full  = tx_cnt[AW];
    wire  [AW:0]          tx_free  = DEPTH[AW:0] - tx_cnt;
    // Bytes sampled on the link edge; dropped if buffer full (far side ignored status)
    wire                  tx_push  = tx_link_clock_rise && !tval_s_q[1] && tx_sel && !tx_full;
    wire                  tx_pop   = CORE_TX_VALID && CORE_TX_READY;
    wire                  tx_has_data  = (tx_cnt != '0);
    wire                  tx_room_cell = (tx_free >= (AW+1)'(CELL_LEN));
    wire                  tx_status_d  = cell_hs ? tx_room_cell : !tx_full; // low means full, or in cell mode no room for a whole cell
    wire                  tx_hiz       = multi_phy && !tx_sel;

    always_ff @(posedge REF_CLK) begin
        if (tx_push) begin
            tx_mem[tx_wp_q[AW-1:0]]     <= tdat_s2_q;
            tx_soc_mem[tx_wp_q[AW-1:0]] <= tx_cell_start_s_q[1];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            tx_wp_q       <= '0;
            tx_rp_q       <= '0;
            CORE_TX_BYTE  <= 8'h00;
            CORE_TX_SOC   <= 1'b0;
            CORE_TX_VALID <= 1'b0;
        end else begin
            if (tx_push) begin
                tx_wp_q <= tx_wp_q + 1'b1;
            end
            // Output register reloads when empty or consumed
            if (!CORE_TX_VALID || CORE_TX_READY) begin
                CORE_TX_VALID <= tx_has_data;
                CORE_TX_BYTE  <= tx_mem[tx_rp_q[AW-1:0]];
                CORE_TX_SOC   <= tx_soc_mem[tx_rp_q[AW-1:0]];
                if (tx_has_data) begin
                    tx_rp_q <= tx_rp_q + 1'b1;
                end
            end
        end
    end

    // Status moves with the link edge so the far side sees it settled
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            TX_STATUS <= 1'b0;
        end else if (tx_link_clock_rise) begin
            TX_STATUS <= tx_status_d;
        end
    end

    // Release is prompt, like the receive side
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            TX_STATUS_OE_N <= 1'b1;
        end else begin
            TX_STATUS_OE_N <= tx_hiz;
        end
    end
endmodule

// *** tb/cell_port_checker.sv ***
// Port checker for the PHY cell port
`timescale 1ns/10ps
module cell_port_checker #(parameter int CELL_LEN = 53, parameter bit [4:0] PHY_ADDR = 5'h00) (
    input wire logic       REF_CLK,
    input wire logic       RST_N,
    input wire logic       CELL_MODE,
    input wire logic       MULTI_PHY_SELECT,
    input wire logic       RX_LINK_CLOCK,
    input wire logic [7:0] RX_BYTE_BUS,
    input wire logic [7:0] RX_BYTE_BUS_OE_N,
    input wire logic       RX_CELL_START,
    input wire logic       RX_STATUS,
    input wire logic [4:0] RX_PHY_SELECT_ADDR,
    input wire logic       CORE_RX_VALID,
    input wire logic       CORE_RX_READY,
    input wire logic       TX_LINK_CLOCK,
    input wire logic       TX_VALID_N,
    input wire logic [4:0] TX_PHY_SELECT_ADDR,
    input wire logic       TX_STATUS_OE_N,
    input wire logic       CORE_TX_VALID
);
    logic [3:0] rx_age_q;
    logic [4:0] tx_age_q;
    logic [5:0] wr_cnt_q;
    // Ages saturate so a quiet link never wraps into a false window
    always_ff @(posedge REF_CLK) begin
        rx_age_q <= !RST_N ? 4'hF : $rose(RX_LINK_CLOCK) ? 4'h0 : rx_age_q + {3'h0, ~&rx_age_q};
        tx_age_q <= !RST_N ? 5'h1F : ($rose(TX_LINK_CLOCK) && !TX_VALID_N) ? 5'h00 : tx_age_q + {4'h0, ~&tx_age_q};
        wr_cnt_q <= !RST_N ? 6'h00 : wr_cnt_q + {5'h00, CORE_RX_VALID && CORE_RX_READY && ~&wr_cnt_q};
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_link_win; rx_age_q inside {[4'h1:4'h6]}; endsequence
    sequence s_unsel(logic [4:0] a); MULTI_PHY_SELECT && a != PHY_ADDR; endsequence
    AST_RX_CHANGE: assert property ($changed(RX_BYTE_BUS) |-> s_link_win) else $error("rx byte off edge");
    AST_RX_SOC: assert property ($rose(RX_CELL_START) |-> s_link_win) else $error("rx start off edge");
    AST_RX_EMPTY: assert property (!CELL_MODE && CORE_RX_VALID && CORE_RX_READY |-> ##[1:24] RX_STATUS) else $error("rx empty");
    AST_RX_CELL: assert property (CELL_MODE [*6] ##0 RX_STATUS |-> wr_cnt_q >= CELL_LEN) else $error("rx cell");
    AST_SINGLE_OE: assert property (!MULTI_PHY_SELECT [*8] |-> RX_BYTE_BUS_OE_N == 8'h00 && !TX_STATUS_OE_N) else $error("oe");
    AST_RX_UNSEL: assert property (s_unsel(RX_PHY_SELECT_ADDR) [*8] |-> &RX_BYTE_BUS_OE_N) else $error("rx unsel");
    AST_TX_UNSEL: assert property (s_unsel(TX_PHY_SELECT_ADDR) [*8] |-> TX_STATUS_OE_N) else $error("tx unsel");
    AST_TX_TAKE: assert property ($rose(CORE_TX_VALID) |-> tx_age_q <= 5'd12) else $error("tx byte untaken");
endmodule
bind utopia_phy_cell_port cell_port_checker #(.CELL_LEN(CELL_LEN), .PHY_ADDR(PHY_ADDR)) u_cell_port_checker (.*);

// *** tb/atm_master_model.sv ***
// Behavioural ATM-layer master for both link directions
`timescale 1ns/10ps
module atm_master_model (
    input  wire logic       ref_clk,
    output logic            rx_link,
    output logic            tx_link,
    output logic [7:0]      tx_bus,
    output logic            tx_soc,
    output logic            tx_valid_n,
    output logic            rx_accept_n,
    input  wire logic [7:0] rx_bus,
    input  wire logic       rx_soc
);
    logic [8:0] rx_q[$];
    // Links free-run at 6.25 MHz; tx also clocks management so never stops
    initial begin
        {rx_link, tx_link, tx_bus, tx_soc} = '0;
        {tx_valid_n, rx_accept_n} = 2'b11;
        fork
            #3 forever #80 rx_link = ~rx_link;
            #41 forever #80 tx_link = ~tx_link;
        join
    end
    // Moves on the falling link edge, clear of the rising sample
    task automatic send(input logic [7:0] b, input logic s, input logic v_n);
        @(negedge tx_link);
        @(posedge ref_clk);
        tx_bus <= v_n ? ~tx_bus : b;
        tx_soc <= s;
        tx_valid_n <= v_n;
    endtask
    task automatic take(input int n);
        @(negedge rx_link);
        @(posedge ref_clk);
        rx_accept_n <= 1'b0;
        repeat (n) begin
            @(negedge rx_link);
            rx_q.push_back({rx_soc, rx_bus});
        end
        @(posedge ref_clk);
        rx_accept_n <= 1'b1;
    endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the PHY cell port
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; $display("mismatch %s exp %0h seen %0h", n, e, a); end end
module tb;
    logic       REF_CLK, RST_N, CELL_MODE, MULTI_PHY_SELECT, RX_LINK_CLOCK, RX_ACCEPT_N, TX_LINK_CLOCK, TX_CELL_START;
    logic       TX_VALID_N, CORE_RX_SOC, CORE_RX_VALID, CORE_TX_READY, RX_CELL_START, RX_CELL_START_OE_N, RX_STATUS;
    logic       RX_STATUS_OE_N, CORE_RX_READY, TX_STATUS, TX_STATUS_OE_N, CORE_TX_SOC, CORE_TX_VALID;
    logic [7:0] RX_BYTE_BUS, RX_BYTE_BUS_OE_N, CORE_RX_BYTE, TX_BYTE_BUS, CORE_TX_BYTE;
    logic [4:0] RX_PHY_SELECT_ADDR, TX_PHY_SELECT_ADDR;
    logic [8:0] tx_q[$];
    int         error_cnt = 0, samples_checked = 0, cyc_cnt = 0;
    utopia_phy_cell_port u_utopia_phy_cell_port (.*);
    atm_master_model u_atm_master_model (.ref_clk(REF_CLK), .rx_link(RX_LINK_CLOCK), .tx_link(TX_LINK_CLOCK),
        .tx_bus(TX_BYTE_BUS), .tx_soc(TX_CELL_START), .tx_valid_n(TX_VALID_N), .rx_accept_n(RX_ACCEPT_N),
        .rx_bus(RX_BYTE_BUS), .rx_soc(RX_CELL_START));
    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK) begin
        if (CORE_TX_VALID === 1'b1 && CORE_TX_READY === 1'b1) tx_q.push_back({CORE_TX_SOC, CORE_TX_BYTE});
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask
    task automatic wr(input logic [7:0] b, input logic s);
        @(posedge REF_CLK);
        {CORE_RX_BYTE, CORE_RX_SOC, CORE_RX_VALID} <= {b, s, 1'b1};
        do @(posedge REF_CLK); while (CORE_RX_READY !== 1'b1);
        CORE_RX_VALID <= 1'b0;
    endtask
    task automatic t_rx;
        for (int i = 0; i < 52; i++) wr(8'h40 + i[7:0], i == 0);
        wait_cyc(24);
        `CHK("rx_status", 1'b0, RX_STATUS)
        wr(8'h74, 1'b0);
        wait_cyc(24);
        `CHK("rx_status", 1'b1, RX_STATUS)
        u_atm_master_model.take(53);
        for (int i = 0; i < 53; i++) `CHK("rx_byte", {i == 0, 8'h40 + i[7:0]}, u_atm_master_model.rx_q[i])
        CELL_MODE <= 1'b0;
        wait_cyc(24);
        `CHK("rx_status", 1'b0, RX_STATUS)
        wr(8'hA5, 1'b1);
        wait_cyc(24);
        `CHK("rx_status", 1'b1, RX_STATUS)
    endtask
    task automatic t_tx;
        for (int i = 0; i < 53; i++) begin
            if (i == 20) u_atm_master_model.send(8'h00, 1'b0, 1'b1);
            u_atm_master_model.send(8'h80 + i[7:0], i == 0, 1'b0);
        end
        u_atm_master_model.send(8'h00, 1'b0, 1'b1);
        wait_cyc(40);
        `CHK("tx_count", 53, tx_q.size())
        for (int i = 0; i < 53; i++) `CHK("tx_byte", {i == 0, 8'h80 + i[7:0]}, tx_q[i])
    endtask
    task automatic t_full;
        CORE_TX_READY <= 1'b0;
        for (int i = 0; i < 140; i++) u_atm_master_model.send(i[7:0], i % 53 == 0, 1'b0);
        u_atm_master_model.send(8'h00, 1'b0, 1'b1);
        wait_cyc(20);
        `CHK("tx_full", 1'b0, TX_STATUS)
        CELL_MODE <= 1'b1;
        wait_cyc(24);
        `CHK("tx_room", 1'b0, TX_STATUS)
        CORE_TX_READY <= 1'b1;
        wait_cyc(200);
        `CHK("tx_room", 1'b1, TX_STATUS)
        `CHK("tx_kept", 182, tx_q.size())
        `CHK("tx_cell3", {1'b1, 8'h6A}, tx_q[159])
    endtask
    task automatic t_multi;
        {MULTI_PHY_SELECT, RX_PHY_SELECT_ADDR, TX_PHY_SELECT_ADDR} <= {1'b1, 5'h01, 5'h01};
        wait_cyc(12);
        `CHK("oe_unsel", 11'h7FF, {RX_BYTE_BUS_OE_N, TX_STATUS_OE_N, RX_CELL_START_OE_N, RX_STATUS_OE_N})
        {RX_PHY_SELECT_ADDR, TX_PHY_SELECT_ADDR} <= 10'h000;
        wait_cyc(12);
        `CHK("oe_sel", 11'h000, {RX_BYTE_BUS_OE_N, TX_STATUS_OE_N, RX_CELL_START_OE_N, RX_STATUS_OE_N})
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        {RST_N, CORE_RX_VALID, CORE_RX_SOC, MULTI_PHY_SELECT, CORE_RX_BYTE} = '0;
        {CELL_MODE, CORE_TX_READY, RX_PHY_SELECT_ADDR, TX_PHY_SELECT_ADDR} = 12'hC00;
        repeat (6) @(posedge REF_CLK);
        RST_N <= 1'b1;
        wait_cyc(24);
        `CHK("tx_room", 1'b1, TX_STATUS)
        `CHK("rx_oe", 8'h00, RX_BYTE_BUS_OE_N)
        t_rx();
        t_tx();
        t_full();
        t_multi();
        end_of_test();
    end
endmodule
